// ==== src/hsk_pkg.sv ====
// Register map, field layout, types and helpers of the housekeeping converter control.
// Behaviour
// R1 - Temperature delta beyond limit raises converter interrupt.
// R2 - Single temperature completion raises converter interrupt.
// R3 - Temperature result reloads per interrupt; no flag.
// R4 - Battery result is eight bits, 15 mV steps.
// R5 - Battery start bit runs one conversion, interrupts.
// R6 - Nonzero battery interval repeats conversions in background.
// R7 - Background battery below threshold sets low-battery flag.
// R8 - Low-battery flag gated by its enable bit.
// R9 - Single battery completion also sets battery flag.
// R10 - Battery result changes only when flag sets.
// R11 - Battery single/background availability follows power mode.
// R12 - Supply start bit runs one conversion, interrupts.
// R13 - No background supply conversions until interval set.
// R14 - Background supply change beyond delta sets flag.
// R15 - Supply-change flag gated by its enable bit.
// R16 - Software: single conversion, then delta, then interval.
// R17 - Supply single/background availability follows power mode.
// R18 - Supply result changes only on supply interrupt.
// R19 - Start bits: supply 2, temperature 1, battery 0.
// R20 - Stored reference replaced at each channel interrupt.
// R21 - One conversion at a time; requests held pending.
package hsk_pkg;

  // ****************************************************************
  // Register addresses and reset values
  // ****************************************************************
  localparam logic [7:0] HSK_ADDR_TEMP_RESULT = 8'hd7;
  localparam logic [7:0] HSK_ADDR_START       = 8'hd8;
  localparam logic [7:0] HSK_ADDR_BAT_RESULT  = 8'hdf;
  localparam logic [7:0] HSK_ADDR_IRQ_ENABLE  = 8'hec;
  localparam logic [7:0] HSK_ADDR_SUP_RESULT  = 8'hef;
  localparam logic [7:0] HSK_ADDR_DELTA       = 8'hf3;
  localparam logic [7:0] HSK_ADDR_IRQ_FLAGS   = 8'hf8;
  localparam logic [7:0] HSK_ADDR_STROBE_PER  = 8'hf9;
  localparam logic [7:0] HSK_ADDR_BAT_THRESH  = 8'hfa;
  localparam logic [7:0] HSK_RESET_VALUE      = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int HSK_NUM_CH        = 3;
  localparam int HSK_CH_BAT        = 0;
  localparam int HSK_CH_TEMP       = 1;
  localparam int HSK_CH_SUP        = 2;
  localparam int HSK_BAT_IVL_LSB   = 0;
  localparam int HSK_SUP_IVL_LSB   = 2;
  localparam int HSK_TEMP_IVL_LSB  = 4;
  localparam int HSK_SUP_DELTA_LSB = 0;
  localparam int HSK_TMP_DELTA_LSB = 3;
  localparam int HSK_FLAG_LOW_BAT  = 0;
  localparam int HSK_FLAG_SUP_CHG  = 1;
  localparam int HSK_BAT_MV_PER_LSB = 15;

  // Power mode codes presented on the mode input.
  localparam logic [1:0] HSK_MODE_FULL_ACTIVE = 2'h0;
  localparam logic [1:0] HSK_MODE_BAT_ACTIVE  = 2'h1;
  localparam logic [1:0] HSK_MODE_CPU_OFF     = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    HSK_IDLE = 2'b01,
    HSK_BUSY = 2'b10
  } hsk_state_t;

  typedef struct packed {
    logic       valid;
    logic       single;
    logic [1:0] chan;
  } hsk_grant_t;

  typedef struct packed {
    logic       done;
    logic [7:0] data;
  } hsk_result_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } hsk_sfr_req_t;

  // True when the two results differ by more than the programmed delta.
  function automatic logic hsk_delta_exceeds(input logic [7:0] a, input logic [7:0] b, input logic [2:0] d);
    logic [7:0] diff;
    diff = (a > b) ? (a - b) : (b - a);
    return diff > {5'h00, d};
  endfunction

endpackage

// ==== src/hsk_sticky_flags.sv ====
// Sticky power-monitor flag register where a hardware set wins over a software write.
`timescale 1ns/1ps
module hsk_sticky_flags
  import hsk_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] hw_set,
  input  wire logic       sw_we,
  input  wire logic [7:0] sw_wdata,
  output logic      [7:0] flags_q
);

  // Software writes the whole byte; a set arriving in the same cycle is kept.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flags_q <= HSK_RESET_VALUE;
    end
    else
    begin
      flags_q <= (sw_we ? sw_wdata : flags_q) | hw_set;
    end
  end

  a_set_wins : assert property (@(posedge clk) disable iff (srst) (hw_set != 8'h00) |=> ((flags_q & $past(hw_set)) == $past(hw_set))) // R7
    else $error("Hardware flag set was lost.");

endmodule

// ==== src/hsk_conv_arb.sv ====
// Arbiter that serialises single and background requests onto the shared converter.
`timescale 1ns/1ps
module hsk_conv_arb
  import hsk_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] single_req,
  input  wire logic [2:0] bkg_req,
  input  wire logic       conv_done,
  output hsk_grant_t      grant,
  output hsk_grant_t      active_q
);

  hsk_state_t state_q;

  // Lowest channel index wins; a single request beats a background one on the same channel.
  always_comb
  begin
    grant = '0;
    if (state_q == HSK_IDLE)
    begin
      for (int i = HSK_NUM_CH - 1; i >= 0; i--)
      begin
        if (single_req[i] || bkg_req[i])
        begin
          grant.valid  = 1'b1;
          grant.single = single_req[i];
          grant.chan   = 2'(i);
        end
      end
    end
  end

  // Only one conversion is in flight; others stay pending upstream.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= HSK_IDLE;
    end
    else
    begin
      case (state_q)
        HSK_IDLE: if (grant.valid) state_q <= HSK_BUSY; // R21
        HSK_BUSY: if (conv_done) state_q <= HSK_IDLE;
        default:  state_q <= HSK_IDLE;
      endcase
    end
  end

  // Remember which channel and kind the converter is working on.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      active_q <= '0;
    end
    else if (grant.valid)
    begin
      active_q <= grant;
    end
    else if (conv_done)
    begin
      active_q <= '0;
    end
  end

  a_one_at_time : assert property (@(posedge clk) disable iff (srst) grant.valid |=> !grant.valid) // R21
    else $error("Second conversion granted while one is running.");

endmodule

// ==== src/hsk_adc_ctrl.sv ====
// Top of the housekeeping converter control: registers, scheduling and result handling.
`timescale 1ns/1ps
module hsk_adc_ctrl
  import hsk_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  hsk_sfr_req_t      sfr_req,
  output logic        [7:0] sfr_rdata_q,
  input  wire logic   [1:0] pwr_mode,
  input  wire logic         bat_strobe,
  input  wire logic         temp_strobe,
  input  wire logic         sup_strobe,
  output logic        [7:0] strobe_period_q,
  output hsk_grant_t        conv_req,
  input  hsk_result_t       conv_result,
  output logic              adc_irq_q,
  output logic              psm_irq
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [2:0] start_q;
  logic [7:0] temp_result_q;
  logic [7:0] battery_result_q;
  logic [7:0] supply_result_q;
  logic [7:0] irq_enable_q;
  logic [7:0] delta_cfg_q;
  logic [7:0] bat_thresh_q;
  logic [7:0] flags_q;
  logic [7:0] flag_set;
  logic [7:0] temp_ref_q;
  logic [7:0] supply_ref_q;
  logic [2:0] bkg_pend_q;
  hsk_grant_t active_q;

  logic       wr_start;
  logic       single_ok;
  logic       bkg_ok;
  logic [2:0] ivl_set;
  logic [2:0] strobe_in;
  logic       done_evt;
  logic       done_temp;
  logic       done_sup;
  logic       done_bat;
  logic       temp_irq;
  logic       sup_irq;
  logic       bat_flag_set;
  logic       sup_flag_set;

  // ****************************************************************
  // Write decode and mode gating
  // ****************************************************************
  assign wr_start = sfr_req.wr && (sfr_req.addr == HSK_ADDR_START);

  // Single requests need a running processor; background needs the monitor powered.
  assign single_ok = (pwr_mode == HSK_MODE_FULL_ACTIVE) || (pwr_mode == HSK_MODE_BAT_ACTIVE); // R11 R17
  assign bkg_ok    = (pwr_mode == HSK_MODE_FULL_ACTIVE) || (pwr_mode == HSK_MODE_CPU_OFF);    // R11 R17

  // A channel only strobes in the background when its interval field is nonzero.
  assign ivl_set[HSK_CH_BAT]  = strobe_period_q[HSK_BAT_IVL_LSB +: 2] != 2'h0;  // R6
  assign ivl_set[HSK_CH_TEMP] = strobe_period_q[HSK_TEMP_IVL_LSB +: 2] != 2'h0;
  assign ivl_set[HSK_CH_SUP]  = strobe_period_q[HSK_SUP_IVL_LSB +: 2] != 2'h0;  // R13
  assign strobe_in = {sup_strobe, temp_strobe, bat_strobe};

  // ****************************************************************
  // Converter arbitration
  // ****************************************************************
  hsk_conv_arb u_arb (
    .clk        (clk),
    .srst       (srst),
    .single_req (start_q & {3{single_ok}}),
    .bkg_req    (bkg_pend_q & {3{bkg_ok}}),
    .conv_done  (conv_result.done),
    .grant      (conv_req),
    .active_q   (active_q)
  );

  // Start bits; a fresh software write wins over the clear on acceptance.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      start_q <= HSK_RESET_VALUE[2:0];
    end
    else if (wr_start)
    begin
      start_q <= sfr_req.wdata[2:0]; // R5 R19
    end
    else if (conv_req.valid && conv_req.single)
    begin
      start_q[conv_req.chan] <= 1'b0; // R19
    end
  end

  // Background strobes are latched until the converter takes them, so none is dropped.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bkg_pend_q <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < HSK_NUM_CH; i++)
      begin
        if (strobe_in[i] && ivl_set[i])
        begin
          bkg_pend_q[i] <= 1'b1; // R6 R13 R21
        end
        else if (!ivl_set[i])
        begin
          bkg_pend_q[i] <= 1'b0; // R13
        end
        else if (conv_req.valid && !conv_req.single && (conv_req.chan == 2'(i)))
        begin
          bkg_pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Completion decode
  // ****************************************************************
  assign done_evt  = conv_result.done && active_q.valid;
  assign done_temp = done_evt && (active_q.chan == 2'(HSK_CH_TEMP));
  assign done_sup  = done_evt && (active_q.chan == 2'(HSK_CH_SUP));
  assign done_bat  = done_evt && (active_q.chan == 2'(HSK_CH_BAT));

  // Temperature interrupts on a single result or on a large enough change.
  assign temp_irq = done_temp && (active_q.single ||
                    hsk_delta_exceeds(conv_result.data, temp_ref_q,
                                      delta_cfg_q[HSK_TMP_DELTA_LSB +: 3])); // R1 R2
  // Supply single results interrupt directly; background ones only on a large change.
  assign sup_flag_set = done_sup && !active_q.single &&
                        hsk_delta_exceeds(conv_result.data, supply_ref_q,
                                          delta_cfg_q[HSK_SUP_DELTA_LSB +: 3]); // R14
  assign sup_irq = (done_sup && active_q.single) || sup_flag_set; // R12
  // Battery flag on a single result or a background result below threshold.
  assign bat_flag_set = done_bat && (active_q.single || (conv_result.data < bat_thresh_q)); // R7 R9

  // ****************************************************************
  // Results and stored references
  // ****************************************************************
  // The temperature result has no flag; it is reloaded with each of its interrupts.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      temp_result_q <= HSK_RESET_VALUE;
      temp_ref_q    <= HSK_RESET_VALUE;
    end
    else if (temp_irq)
    begin
      temp_result_q <= conv_result.data; // R3
      temp_ref_q    <= conv_result.data; // R20
    end
  end

  // Supply result and reference move only on a supply interrupt, so small drift accumulates.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      supply_result_q <= HSK_RESET_VALUE;
      supply_ref_q    <= HSK_RESET_VALUE;
    end
    else if (sup_irq)
    begin
      supply_result_q <= conv_result.data; // R18
      supply_ref_q    <= conv_result.data; // R20
    end
  end

  // Battery code is 8 bits at fixed millivolt steps; held unless the flag sets.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      battery_result_q <= HSK_RESET_VALUE;
    end
    else if (bat_flag_set)
    begin
      battery_result_q <= conv_result.data; // R4 R5 R10
    end
  end

  // Converter interrupt pulse for temperature and supply events.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      adc_irq_q <= 1'b0;
    end
    else
    begin
      adc_irq_q <= temp_irq || sup_irq; // R2 R12
    end
  end

  // ****************************************************************
  // Power-monitor flags and interrupt
  // ****************************************************************
  always_comb
  begin
    flag_set                   = 8'h00;
    flag_set[HSK_FLAG_LOW_BAT] = bat_flag_set; // R7 R9
    flag_set[HSK_FLAG_SUP_CHG] = sup_flag_set; // R14
  end

  hsk_sticky_flags u_flags (
    .clk              (clk),
    .srst             (srst),
    .hw_set           (flag_set),
    .sw_we            (sfr_req.wr && (sfr_req.addr == HSK_ADDR_IRQ_FLAGS)),
    .sw_wdata         (sfr_req.wdata),
    .flags_q          (flags_q)
  );

  // Each flag reaches the power-monitor line only through its enable bit.
  assign psm_irq = (flags_q[HSK_FLAG_LOW_BAT] && irq_enable_q[HSK_FLAG_LOW_BAT]) || // R8
                   (flags_q[HSK_FLAG_SUP_CHG] && irq_enable_q[HSK_FLAG_SUP_CHG]);    // R15

  // ****************************************************************
  // Software-written configuration registers
  // ****************************************************************
  // Software must run a single supply conversion before setting delta and interval.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_enable_q    <= HSK_RESET_VALUE;
      delta_cfg_q     <= HSK_RESET_VALUE;
      strobe_period_q <= HSK_RESET_VALUE; // R13
      bat_thresh_q    <= HSK_RESET_VALUE;
    end
    else if (sfr_req.wr)
    begin
      case (sfr_req.addr)
        HSK_ADDR_IRQ_ENABLE: irq_enable_q    <= sfr_req.wdata;
        HSK_ADDR_DELTA:      delta_cfg_q     <= sfr_req.wdata; // R16
        HSK_ADDR_STROBE_PER: strobe_period_q <= sfr_req.wdata;
        HSK_ADDR_BAT_THRESH: bat_thresh_q    <= sfr_req.wdata;
        default:             bat_thresh_q    <= bat_thresh_q;
      endcase
    end
  end

  // Read data is registered one cycle after the address; unmapped addresses read zero.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sfr_rdata_q <= HSK_RESET_VALUE;
    end
    else
    begin
      case (sfr_req.addr)
        HSK_ADDR_TEMP_RESULT: sfr_rdata_q <= temp_result_q;
        HSK_ADDR_START:       sfr_rdata_q <= {5'h00, start_q};
        HSK_ADDR_BAT_RESULT:  sfr_rdata_q <= battery_result_q;
        HSK_ADDR_IRQ_ENABLE:  sfr_rdata_q <= irq_enable_q;
        HSK_ADDR_SUP_RESULT:  sfr_rdata_q <= supply_result_q;
        HSK_ADDR_DELTA:       sfr_rdata_q <= delta_cfg_q;
        HSK_ADDR_IRQ_FLAGS:   sfr_rdata_q <= flags_q;
        HSK_ADDR_STROBE_PER:  sfr_rdata_q <= strobe_period_q;
        HSK_ADDR_BAT_THRESH:  sfr_rdata_q <= bat_thresh_q;
        default:              sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_temp_single : assert property (@(posedge clk) disable iff (srst) // R2
    (done_temp && active_q.single) |=> (adc_irq_q && (temp_result_q == $past(conv_result.data))))
    else $error("Single temperature result did not interrupt.");

  a_temp_delta : assert property (@(posedge clk) disable iff (srst) // R1
    (done_temp && !active_q.single && !hsk_delta_exceeds(conv_result.data, temp_ref_q,
     delta_cfg_q[HSK_TMP_DELTA_LSB +: 3])) |=> (!adc_irq_q && $stable(temp_result_q)))
    else $error("Temperature interrupt without enough change.");

  a_bat_low : assert property (@(posedge clk) disable iff (srst) // R7
    (done_bat && (conv_result.data < bat_thresh_q)) |=> flags_q[HSK_FLAG_LOW_BAT])
    else $error("Low battery flag not set.");

  a_bat_hold : assert property (@(posedge clk) disable iff (srst) // R10
    !bat_flag_set |=> $stable(battery_result_q))
    else $error("Battery result moved without flag.");

  a_sup_hold : assert property (@(posedge clk) disable iff (srst) // R18
    !sup_irq |=> $stable(supply_result_q))
    else $error("Supply result moved without interrupt.");

  a_sup_ref : assert property (@(posedge clk) disable iff (srst) // R20
    sup_flag_set |=> (supply_ref_q == $past(conv_result.data)) && flags_q[HSK_FLAG_SUP_CHG])
    else $error("Supply reference or flag not updated.");

  a_mode_gate : assert property (@(posedge clk) disable iff (srst) // R11
    conv_req.valid |-> (conv_req.single ? (pwr_mode != HSK_MODE_CPU_OFF) : (pwr_mode != HSK_MODE_BAT_ACTIVE)))
    else $error("Conversion granted in a forbidden power mode.");

  a_start_clear : assert property (@(posedge clk) disable iff (srst) // R19
    (conv_req.valid && conv_req.single && !wr_start) |=> !start_q[$past(conv_req.chan)])
    else $error("Start bit not cleared on acceptance.");

  a_psm_gate : assert property (@(posedge clk) disable iff (srst) // R8
    (!irq_enable_q[HSK_FLAG_LOW_BAT] && !irq_enable_q[HSK_FLAG_SUP_CHG]) |-> !psm_irq)
    else $error("Power-monitor interrupt while sources disabled.");

  a_sup_no_bkg : assert property (@(posedge clk) disable iff (srst) // R13
    (strobe_period_q[HSK_SUP_IVL_LSB +: 2] == 2'h0) |=> !bkg_pend_q[HSK_CH_SUP])
    else $error("Background supply pending with interval zero.");

  a_sup_single : assert property (@(posedge clk) disable iff (srst) // R12
    (done_sup && active_q.single) |=> (adc_irq_q && (supply_result_q == $past(conv_result.data))))
    else $error("Single supply result did not interrupt.");

  a_bat_single : assert property (@(posedge clk) disable iff (srst) // R5
    (done_bat && active_q.single) |=> (flags_q[HSK_FLAG_LOW_BAT] && (battery_result_q == $past(conv_result.data))))
    else $error("Single battery result did not set the flag.");

  a_temp_ref : assert property (@(posedge clk) disable iff (srst) // R20
    temp_irq |=> (temp_ref_q == $past(conv_result.data)))
    else $error("Temperature reference not replaced at interrupt.");

  a_temp_no_flag : assert property (@(posedge clk) disable iff (srst) // R3
    (temp_irq && !(sfr_req.wr && (sfr_req.addr == HSK_ADDR_IRQ_FLAGS))) |=> $stable(flags_q))
    else $error("Temperature interrupt touched the flag register.");

  a_bat_forward : assert property (@(posedge clk) disable iff (srst) // R8
    (flags_q[HSK_FLAG_LOW_BAT] && irq_enable_q[HSK_FLAG_LOW_BAT]) |-> psm_irq)
    else $error("Enabled low battery flag not forwarded.");

  a_sup_forward : assert property (@(posedge clk) disable iff (srst) // R15
    (flags_q[HSK_FLAG_SUP_CHG] && irq_enable_q[HSK_FLAG_SUP_CHG]) |-> psm_irq)
    else $error("Enabled supply change flag not forwarded.");

  a_sup_pending : assert property (@(posedge clk) disable iff (srst) // R21
    (sup_strobe && ivl_set[HSK_CH_SUP]) |=> bkg_pend_q[HSK_CH_SUP])
    else $error("Background supply strobe was dropped.");

endmodule

// ==== dv/hsk_conv_model.sv ====
// Behavioural model of the shared converter that answers the conversion grants.
`timescale 1ns/1ps
module hsk_conv_model
  import hsk_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  hsk_grant_t      conv_req,
  input  wire logic [7:0] next_data,
  input  wire logic       slow,
  output hsk_result_t     conv_result
);
  // ****************************************************************
  // Conversion timing
  // ****************************************************************
  int wait_n;

  initial
  begin
    wait_n = 0;
    conv_result = '0;
  end

  // A grant is taken at the rising edge; slow mode stretches the conversion at random.
  always @(posedge clk)
  begin
    if (srst)
      wait_n = 0;
    else if (conv_req.valid)
      wait_n = slow ? 1 + int'($urandom % 12) : 1;
  end

  // The result stands for one cycle only; otherwise the data lines toggle so stale data never looks valid.
  always @(negedge clk)
  begin
    if (wait_n == 1)
    begin
      conv_result.done <= 1'b1;
      conv_result.data <= next_data;
    end
    else
    begin
      conv_result.done <= 1'b0;
      conv_result.data <= ~conv_result.data;
    end
    if (wait_n > 0)
      wait_n = wait_n - 1;
  end
endmodule

// ==== dv/tb.sv ====
// Self-checking testbench of the housekeeping converter control with a reference model.
`timescale 1ns/1ps
module tb
  import hsk_pkg::*;
;
  logic clk, srst, slow, adc_irq_q, psm_irq;
  logic [7:0] sfr_rdata_q, strobe_period_q, next_data;
  logic [1:0] pwr_mode;
  logic [2:0] stb;
  hsk_sfr_req_t sfr_req;
  hsk_grant_t conv_req;
  hsk_result_t conv_result;
  int miscompares, samples_checked, n_done, n_grant, a_ch, t_ref, s_ref, ch, d, rv;
  int mreg[256];
  bit busy, a_single, irq_exp;
  logic [7:0] amap[10] = '{8'hd7, 8'hd8, 8'hdf, 8'hec, 8'hef, 8'hf3, 8'hf8, 8'hf9, 8'hfa, 8'h00};

  hsk_adc_ctrl dut (.clk(clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q), .pwr_mode(pwr_mode),
    .bat_strobe(stb[0]), .temp_strobe(stb[1]), .sup_strobe(stb[2]), .strobe_period_q(strobe_period_q),
    .conv_req(conv_req), .conv_result(conv_result), .adc_irq_q(adc_irq_q), .psm_irq(psm_irq));
  hsk_conv_model conv (.clk(clk), .srst(srst), .conv_req(conv_req), .next_data(next_data), .slow(slow),
    .conv_result(conv_result));

  // ****************************************************************
  // Checking and reference model
  // ****************************************************************
  always #10 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // The model sees the same edge as the design, so it compares outputs before applying this edge's updates.
  always @(posedge clk)
  begin
    int hs;
    hs = 0;
    if (srst)
    begin
      foreach (mreg[i]) mreg[i] = 0;
      {busy, irq_exp, t_ref, s_ref} = '0;
    end
    else
    begin
      check("adc_irq", {7'h00, adc_irq_q}, {7'h00, irq_exp});
      check("psm_irq", {7'h00, psm_irq}, 8'(((mreg[8'hf8] & mreg[8'hec] & 3) != 0)));
      check("strobe_copy", strobe_period_q, 8'(mreg[8'hf9]));
      if (busy && conv_req.valid) check("grant_busy", 8'h01, 8'h00);
      irq_exp = 0;
      if (busy && conv_result.done)
      begin
        d = conv_result.data;
        busy = 0;
        n_done++;
        if (a_ch == 0 && (a_single || d < mreg[8'hfa]))
        begin
          mreg[8'hdf] = d;
          hs = 1;
        end
        if (a_ch == 1 && (a_single || ((d > t_ref) ? d - t_ref : t_ref - d) > ((mreg[8'hf3] >> 3) & 7)))
        begin
          mreg[8'hd7] = d;
          t_ref = d;
          irq_exp = 1;
        end
        if (a_ch == 2 && (a_single || ((d > s_ref) ? d - s_ref : s_ref - d) > (mreg[8'hf3] & 7)))
        begin
          mreg[8'hef] = d;
          s_ref = d;
          irq_exp = 1;
          hs = a_single ? 0 : 2;
        end
      end
      if (conv_req.valid)
      begin
        busy = 1;
        n_grant++;
        a_ch = conv_req.chan;
        a_single = conv_req.single;
        if (a_single) mreg[8'hd8] &= ~(1 << a_ch);
      end
      if (sfr_req.wr && sfr_req.addr inside {8'hec, 8'hf3, 8'hf8, 8'hf9, 8'hfa}) mreg[sfr_req.addr] = sfr_req.wdata;
      if (sfr_req.wr && sfr_req.addr == 8'hd8) mreg[8'hd8] = sfr_req.wdata & 7;
      mreg[8'hf8] |= hs;
    end
  end

  // ****************************************************************
  // Register and converter traffic
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfr_req = '{addr: a, wr: 1'b1, wdata: v};
    @(negedge clk);
    sfr_req.wr = 1'b0;
  endtask

  task automatic rd_all;
    foreach (amap[i])
    begin
      @(negedge clk);
      sfr_req.addr = amap[i];
      @(negedge clk);
      check($sformatf("reg_%h", amap[i]), sfr_rdata_q, 8'(mreg[amap[i]]));
    end
  endtask

  task automatic await_done(input int target);
    int k;
    k = 0;
    while (n_done < target && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    check("conv_done", 8'(n_done >= target), 8'h01);
    repeat (2) @(negedge clk);
  endtask

  task automatic pulse(input int c);
    @(negedge clk);
    stb[c] = 1'b1;
    @(negedge clk);
    stb = 3'h0;
  endtask

  task automatic single(input int c, input logic [7:0] v);
    next_data = v;
    wr(HSK_ADDR_START, 8'(1 << c));
    await_done(n_done + 1);
  endtask

  task automatic bkg(input int c, input logic [7:0] v);
    next_data = v;
    pulse(c);
    await_done(n_done + 1);
  endtask

  // Watchdog sized well above the thousand or so cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    {clk, slow, stb, next_data, miscompares, samples_checked, n_done, n_grant} = '0;
    srst = 1'b1;
    sfr_req = '0;
    pwr_mode = HSK_MODE_FULL_ACTIVE;
    rv = $urandom(29229);
    repeat (4) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    rd_all();
    wr(8'h00, 8'hff);
    wr(HSK_ADDR_TEMP_RESULT, 8'hff);
    wr(HSK_ADDR_START, 8'hf8);
    pulse(2);
    repeat (6) @(negedge clk);
    check("no_grant", 8'(n_grant), 8'h00);
    wr(HSK_ADDR_IRQ_ENABLE, 8'h03);
    wr(HSK_ADDR_BAT_THRESH, 8'h80);
    for (ch = 0; ch < 3; ch++) single(ch, 8'($urandom));
    rd_all();
    // Supply single done first, then delta, then interval.
    wr(HSK_ADDR_DELTA, 8'($urandom));
    wr(HSK_ADDR_STROBE_PER, 8'h15);
    slow = 1'b1;
    repeat (40)
    begin
      ch = $urandom % 3;
      d = ($urandom % 2) ? int'($urandom % 256) : (((ch == 2) ? s_ref : t_ref) + int'($urandom % 9) - 4);
      bkg(ch, 8'(d));
    end
    rd_all();
    wr(HSK_ADDR_IRQ_FLAGS, 8'h00);
    wr(HSK_ADDR_IRQ_ENABLE, 8'($urandom));
    bkg(0, 8'h10);
    // Held requests in restricted modes are served once the mode allows them.
    pwr_mode = HSK_MODE_BAT_ACTIVE;
    rv = n_grant;
    pulse(0);
    repeat (10) @(negedge clk);
    check("bkg_in_bat_mode", 8'(n_grant - rv), 8'h00);
    single(2, 8'h5a);
    pwr_mode = HSK_MODE_CPU_OFF;
    next_data = 8'h33;
    wr(HSK_ADDR_START, 8'h02);
    repeat (10) @(negedge clk);
    // The battery strobe held in battery mode is served as soon as the processor is off.
    check("single_in_off_mode", 8'(n_grant - rv), 8'h02);
    rd_all();
    bkg(2, 8'h99);
    pwr_mode = HSK_MODE_FULL_ACTIVE;
    await_done(n_done + 1);
    next_data = 8'h44;
    wr(HSK_ADDR_START, 8'h07);
    await_done(n_done + 3);
    rd_all();
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    rd_all();
    give_verdict();
  end
endmodule
